// ---- logic/ieb_bank.sv ----
// Purpose: bank of interrupt enable bits gating peripheral requests
// Assumes: single clock, synchronous active high reset
// Notes: requests come from logic on the same clock
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
module ieb_bank (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [15:0] req_two_i, // word two requests
  input wire logic [15:0] req_three_i, // word three requests
  input wire logic [15:0] req_four_i, // word four requests
  input wire logic [15:0] req_five_i, // word five requests
  output logic [15:0] irq_two_o, // gated word two
  output logic [15:0] irq_three_o, // gated word three
  output logic [15:0] irq_four_o, // gated word four
  output logic [15:0] irq_five_o, // gated word five
  output logic irq_o // any gated request
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [15:0] en_two_ff, en_three_ff, en_four_ff, en_five_ff;
  logic [15:0] nxt_en_two, nxt_en_three, nxt_en_four, nxt_en_five;
  logic [31:0] nxt_dat;
  logic nxt_ack;
  logic ack_ff;
  wire logic req_new = wb_cyc_i && wb_stb_i && !ack_ff;
  // write lands at the edge where ack is seen high, as the master expects
  wire logic wr_go = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i;
  wire logic sel_two = wb_adr_i == ieb_pkg::ADR_WORD_TWO;
  wire logic sel_three = wb_adr_i == ieb_pkg::ADR_WORD_THREE;
  wire logic sel_four = wb_adr_i == ieb_pkg::ADR_WORD_FOUR;
  wire logic sel_five = wb_adr_i == ieb_pkg::ADR_WORD_FIVE;

  function automatic logic [15:0] upd(input logic [15:0] cur,
                                      input logic [15:0] msk,
                                      input logic hit);
    logic [15:0] lane;
    lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    upd = cur;
    if (hit && wr_go) begin
      upd = ((cur & ~lane) | (wb_dat_i[15:0] & lane)) & msk;
    end
  endfunction : upd

  assign nxt_en_two = upd(en_two_ff, ieb_pkg::MASK_WORD_TWO, sel_two);
  assign nxt_en_three = upd(en_three_ff, ieb_pkg::MASK_WORD_THREE,
                            sel_three);
  assign nxt_en_four = upd(en_four_ff, ieb_pkg::MASK_WORD_FOUR, sel_four);
  assign nxt_en_five = upd(en_five_ff, ieb_pkg::MASK_WORD_FIVE, sel_five);
  assign nxt_ack = req_new;
  assign nxt_dat = !req_new ? 32'h00000000 :
                   sel_two ? {16'h0000, en_two_ff} :
                   sel_three ? {16'h0000, en_three_ff} :
                   sel_four ? {16'h0000, en_four_ff} :
                   sel_five ? {16'h0000, en_five_ff} : 32'h00000000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_two_ff <= ieb_pkg::RST_WORD;
      en_three_ff <= ieb_pkg::RST_WORD;
      en_four_ff <= ieb_pkg::RST_WORD;
      en_five_ff <= ieb_pkg::RST_WORD;
      ack_ff <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      en_two_ff <= nxt_en_two;
      en_three_ff <= nxt_en_three;
      en_four_ff <= nxt_en_four;
      en_five_ff <= nxt_en_five;
      ack_ff <= nxt_ack;
      wb_dat_o <= nxt_dat;
    end
  end
  assign wb_ack_o = ack_ff;

  // ---------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------
  wire logic [15:0] g_two = req_two_i & en_two_ff;
  wire logic [15:0] g_three = req_three_i & en_three_ff;
  wire logic [15:0] g_four = req_four_i & en_four_ff;
  wire logic [15:0] g_five = req_five_i & en_five_ff;
  wire logic g_any = |{g_two, g_three, g_four, g_five};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_two_o <= 16'h0000;
      irq_three_o <= 16'h0000;
      irq_four_o <= 16'h0000;
      irq_five_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      irq_two_o <= g_two;
      irq_three_o <= g_three;
      irq_four_o <= g_four;
      irq_five_o <= g_five;
      irq_o <= g_any;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_pass;
    @(posedge clk_i) disable iff (rst_i)
      (req_two_i[ieb_pkg::POS_CAPTURE_CH5] &&
       en_two_ff[ieb_pkg::POS_CAPTURE_CH5]) |=>
      irq_two_o[ieb_pkg::POS_CAPTURE_CH5];
  endproperty
  a_pass: assert property (p_pass) else $error("enabled req lost");

  property p_block;
    @(posedge clk_i) disable iff (rst_i)
      (en_four_ff == 16'h0000) |=> (irq_four_o == 16'h0000);
  endproperty
  a_block: assert property (p_block) else $error("blocked req passed");

  property p_unused_two;
    @(posedge clk_i) disable iff (rst_i)
      (en_two_ff & ~ieb_pkg::MASK_WORD_TWO) == 16'h0000;
  endproperty
  a_unused_two: assert property (p_unused_two)
    else $error("unused bit set in word two");

  property p_fault;
    @(posedge clk_i) disable iff (rst_i)
      (wr_go && sel_two && wb_sel_i[0]) |=>
      en_two_ff[ieb_pkg::POS_SERIAL2_FAULT] ==
      $past(wb_dat_i[ieb_pkg::POS_SERIAL2_FAULT]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault enable wrong");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_go |=> $stable(en_three_ff) && $stable(en_five_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      req_new |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  // ---------------------------------------------------------------
  // bus step sequences
  // ---------------------------------------------------------------
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_write_done;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  endsequence

  sequence s_full_write;
    s_write_done ##0 (wb_sel_i[1:0] == 2'b11);
  endsequence

  // ---------------------------------------------------------------
  // write landing per word
  // ---------------------------------------------------------------
  property p_wr_two;
    @(posedge clk_i) disable iff (rst_i)
      (s_full_write ##0 sel_two) |=>
      en_two_ff == ($past(wb_dat_i[15:0]) & ieb_pkg::MASK_WORD_TWO);
  endproperty
  a_wr_two: assert property (p_wr_two) else $error("word two write");

  property p_wr_three;
    @(posedge clk_i) disable iff (rst_i)
      (s_full_write ##0 sel_three) |=>
      en_three_ff == ($past(wb_dat_i[15:0]) & ieb_pkg::MASK_WORD_THREE);
  endproperty
  a_wr_three: assert property (p_wr_three)
    else $error("word three write");

  property p_wr_four;
    @(posedge clk_i) disable iff (rst_i)
      (s_full_write ##0 sel_four) |=>
      en_four_ff == ($past(wb_dat_i[15:0]) & ieb_pkg::MASK_WORD_FOUR);
  endproperty
  a_wr_four: assert property (p_wr_four)
    else $error("word four write");

  property p_wr_five;
    @(posedge clk_i) disable iff (rst_i)
      (s_full_write ##0 sel_five) |=>
      en_five_ff == ($past(wb_dat_i[15:0]) & ieb_pkg::MASK_WORD_FIVE);
  endproperty
  a_wr_five: assert property (p_wr_five)
    else $error("word five write");

  // ---------------------------------------------------------------
  // word two field positions
  // ---------------------------------------------------------------
  property p_ch3;
    @(posedge clk_i) disable iff (rst_i)
      (s_write_done ##0 (sel_two && wb_sel_i[0])) |=>
      en_two_ff[ieb_pkg::POS_CAPTURE_CH3] ==
      $past(wb_dat_i[ieb_pkg::POS_CAPTURE_CH3]);
  endproperty
  a_ch3: assert property (p_ch3) else $error("ch3 enable wrong");

  property p_event;
    @(posedge clk_i) disable iff (rst_i)
      (s_write_done ##0 (sel_two && wb_sel_i[0])) |=>
      en_two_ff[ieb_pkg::POS_SERIAL2_EVENT] ==
      $past(wb_dat_i[ieb_pkg::POS_SERIAL2_EVENT]);
  endproperty
  a_event: assert property (p_event) else $error("event enable wrong");

  // ---------------------------------------------------------------
  // gating for words two, three and five, and the summary irq
  // ---------------------------------------------------------------
  property p_gate_two;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_two_o == $past(g_two);
  endproperty
  a_gate_two: assert property (p_gate_two) else $error("gate two");

  property p_gate_three;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_three_o == $past(g_three);
  endproperty
  a_gate_three: assert property (p_gate_three) else $error("gate three");

  property p_gate_five;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_five_o == $past(g_five);
  endproperty
  a_gate_five: assert property (p_gate_five) else $error("gate five");

  property p_any;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_o == $past(g_any);
  endproperty
  a_any: assert property (p_any) else $error("summary irq wrong");

  // ---------------------------------------------------------------
  // unused bits and read path
  // ---------------------------------------------------------------
  property p_unused_rest;
    @(posedge clk_i) disable iff (rst_i)
      ((en_three_ff & ~ieb_pkg::MASK_WORD_THREE) == 16'h0000) &&
      ((en_four_ff & ~ieb_pkg::MASK_WORD_FOUR) == 16'h0000) &&
      ((en_five_ff & ~ieb_pkg::MASK_WORD_FIVE) == 16'h0000);
  endproperty
  a_unused_rest: assert property (p_unused_rest)
    else $error("unused bit set");

  property p_read_three;
    @(posedge clk_i) disable iff (rst_i)
      (s_taken ##0 (!wb_we_i && sel_three)) |=>
      wb_dat_o == {16'h0000, $past(en_three_ff)};
  endproperty
  a_read_three: assert property (p_read_three)
    else $error("word three read");

  property p_dat_idle;
    @(posedge clk_i) disable iff (rst_i)
      !req_new |=> wb_dat_o == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data left");

  // reset check runs through reset itself, so no disable
  property p_reset;
    @(posedge clk_i)
      rst_i |=> (en_two_ff == 16'h0000) && (en_three_ff == 16'h0000) &&
      (en_four_ff == 16'h0000) && (en_five_ff == 16'h0000) && !wb_ack_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule : ieb_bank

// ---- logic/ieb_pkg.sv ----
// Purpose: constants for the interrupt enable bank
// Assumes: 32-bit classic Wishbone, one word per register
// Notes: offsets are byte addresses
package ieb_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_WORD_TWO = 4'h0;
  localparam logic [3:0] ADR_WORD_THREE = 4'h4;
  localparam logic [3:0] ADR_WORD_FOUR = 4'h8;
  localparam logic [3:0] ADR_WORD_FIVE = 4'hC;
  // ---------------------------------------------------------------
  // implemented bits
  // ---------------------------------------------------------------
  localparam logic [15:0] MASK_WORD_TWO = 16'h01E3;
  localparam logic [15:0] MASK_WORD_THREE = 16'h4066;
  localparam logic [15:0] MASK_WORD_FOUR = 16'h210E;
  localparam logic [15:0] MASK_WORD_FIVE = 16'h3FBE;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ---------------------------------------------------------------
  // word two field positions
  // ---------------------------------------------------------------
  localparam int POS_CAPTURE_CH6 = 8;
  localparam int POS_CAPTURE_CH5 = 7;
  localparam int POS_CAPTURE_CH4 = 6;
  localparam int POS_CAPTURE_CH3 = 5;
  localparam int POS_SERIAL2_EVENT = 1;
  localparam int POS_SERIAL2_FAULT = 0;
endpackage : ieb_pkg

// ---- test/ieb_req_src.sv ----
// Purpose: peripheral request sources for the enable bank
// Assumes: requests change just after the rising edge
// Notes: words two to five side by side, two lowest
module ieb_req_src (
  input wire logic clk_i, // system clock
  input wire logic [63:0] pat_i, // wanted requests
  output logic [63:0] req_o // raised requests
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i) begin
    req_o <= pat_i;
  end
endmodule : ieb_req_src

// ---- test/test_interrupt_enable_bank.sv ----
// Purpose: self-checking bench for the enable bank
// Assumes: ack one cycle after a request is taken
// Notes: cyc and stb share one driver
module test_interrupt_enable_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, stb = 0, we = 0, ack, irq_o;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [63:0] pat = 64'h0, req, irq;
  int fail_count = 0, total_checks = 0;
  logic [15:0] msk [4] = '{ieb_pkg::MASK_WORD_TWO,
    ieb_pkg::MASK_WORD_THREE, ieb_pkg::MASK_WORD_FOUR,
    ieb_pkg::MASK_WORD_FIVE};
  logic [3:0] ads [4] = '{ieb_pkg::ADR_WORD_TWO,
    ieb_pkg::ADR_WORD_THREE, ieb_pkg::ADR_WORD_FOUR,
    ieb_pkg::ADR_WORD_FIVE};
  ieb_req_src u_src (.clk_i(clk_i), .pat_i(pat), .req_o(req));
  ieb_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(stb),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .req_two_i(req[15:0]), .req_three_i(req[31:16]),
    .req_four_i(req[47:32]), .req_five_i(req[63:48]),
    .irq_two_o(irq[15:0]), .irq_three_o(irq[31:16]),
    .irq_four_o(irq[47:32]), .irq_five_o(irq[63:48]), .irq_o(irq_o));
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
                     logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    {stb, we, adr, wdat, sel} <= {1'b1, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    stb <= 1'b0;
    if (n >= 20) chk("ack", 0, 1);
  endtask : bus
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      bus(0, ads[i], 0);
      chk("reset", rdat, 0);
      bus(1, ads[i], 32'hFFFFFFFF);
      bus(0, ads[i], 0);
      chk("readback", rdat, {16'h0, msk[i]});
    end
    bus(1, 4'h1, 32'hFFFFFFFF);
    bus(0, 4'h1, 0);
    chk("unmapped", rdat, 0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gate();
    pat <= '1;
    repeat (3) @(posedge clk_i);
    chk("irq all", irq, {msk[3], msk[2], msk[1], msk[0]});
    chk("irq_o", irq_o, 1);
    bus(1, ads[0], 32'h00000081);
    for (int i = 1; i < 4; i++) bus(1, ads[i], 0);
    repeat (3) @(posedge clk_i);
    chk("irq ch5 fault", irq, 64'h0081);
    bus(1, ads[0], 32'h00000022);
    repeat (3) @(posedge clk_i);
    chk("irq ch3 event", irq, 64'h0022);
    bus(1, ads[0], 0);
    repeat (3) @(posedge clk_i);
    chk("irq none", irq, 0);
    chk("irq_o low", irq_o, 0);
    $display("test gate done");
  endtask : t_gate
  task automatic t_lanes();
    bus(1, ads[3], 32'h0, 4'h3);
    bus(1, ads[3], 32'hFFFFFFFF, 4'h1);
    bus(0, ads[3], 0);
    chk("lane0", rdat, 64'h00BE);
    bus(1, ads[3], 32'hFFFFFFFF, 4'h2);
    bus(0, ads[3], 0);
    chk("lane1", rdat, 64'h3FBE);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_ext();
    pat <= 64'h0000000000600000;
    bus(1, ads[1], 32'h00000060);
    repeat (3) @(posedge clk_i);
    chk("ext in", irq, 64'h0000000000600000);
    chk("ext irq_o", irq_o, 1);
    $display("test ext done");
  endtask : t_ext
  task automatic t_rst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("rst irq", irq, 0);
    chk("rst irq_o", irq_o, 0);
    bus(0, ads[1], 0);
    chk("rst word", rdat, 0);
    $display("test rst done");
  endtask : t_rst
  initial forever #25 clk_i = ~clk_i;
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_gate();
    t_lanes();
    t_ext();
    t_rst();
    conclude();
  end
endmodule : test_interrupt_enable_bank
